// >>> design/ptp_clock_timestamp_events.sv
// Purpose: PTP clock, frame time stamps, target events, GPIO capture
// Assumes: APB slave, inputs synchronous to clk
// Notes:   One accumulate step per clk cycle
//
// Notes on behaviour
// - The destination address and the control byte qualify a good-FCS frame as PTP.
// - Four fixed multicast addresses, each enabled per port.
// - A programmable user address, enabled per port.
// - Control byte at payload offset 32: 0x00 sync, 0x01 delay request.
// - Payload starts at byte 42 untagged, 46 tagged.
// - Tagged and untagged Ethernet II IPv4 frames only; EtherType and IPv4 header go unchecked.
// - The 64-bit clock is read and written as two words.
// - Snapshot command saves the whole clock for a coherent read.
// - Clock takes a new value once both halves are written.
// - Addend accumulates each cycle; carry increments the clock.
// - Clock equal to target raises the timer event and flag.
// - Reload mode loads the 64-bit reload value as new target.
// - Add mode adds the low reload word to the target.
// - Comparison also applies after clock writes.
// - Clock and target wrap through zero; compare continues.
// - Target and reload commit only after both halves.
// - Flags for each port and direction, each GPIO, and timer.
// - Flags gated by enables and ORed into one summary event.
// - GPIO active edge saves the clock into its capture.
// - Enabled GPIO edge clears the timer flag; >40 ns needed.
// - Master select swaps which type is caught on rx and tx.
// - Matched good frame loads stamp, sequence and source id.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/10ps
module ptp_clock_timestamp_events
	import ptp_tsu_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [7:0]           paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	output      logic [31:0]          prdata,
	output      logic                 pready,
	output      logic                 pslverr,
	input  wire logic [STR_N-1:0]     fr_sof,
	input  wire logic [STR_N-1:0]     fr_vld,
	input  wire logic [8*STR_N-1:0]   fr_byte,
	input  wire logic [STR_N-1:0]     fr_eof,
	input  wire logic [STR_N-1:0]     fr_fcs_ok,
	input  wire logic [GPIO_N-1:0]    gpio_in,
	output      logic                 timestamp_unit_summary_event
);
	// ==========================================================
	// Declarations
	logic [63:0]      clock_q, snap_q, target_q, rld_q;
	logic [31:0]      acc_q, addend_q;
	logic [32:0]      sum;
	logic             carry, eq, eq_q, evt, gated, wr, setup, snap_cmd;
	logic [CFG_W-1:0] cfg_q;
	logic [AEN_W-1:0] aen_q;
	logic [47:0]      usr_q;
	logic [INT_W-1:0] sts_q, sts_d, inten_q, set, clr;
	logic [STR_N-1:0] tsev;
	logic [GPIO_N-1:0] gev;
	logic [2:0]       commit, hf_q, lf_q;
	logic [63:0]      pv [3];
	logic [63:0]      gcap_q [GPIO_N];
	logic [63:0]      cap_clk [STR_N];
	logic [15:0]      cap_seq [STR_N];
	logic [47:0]      cap_uid [STR_N];
	logic [31:0]      rdata_d;
	logic             err_d;
	logic [2:0]       sidx;
	logic [7:0]       goff;

	// ==========================================================
	// APB slave: no wait states, answer registered in setup
	assign setup = psel & ~penable;
	assign wr    = psel & penable & pready & pwrite;
	assign sidx  = paddr[6:4];
	assign goff  = paddr - A_GCAP;

	always_comb begin
		rdata_d = '0;
		err_d   = 1'b0;
		if (paddr == A_CLK_HI) begin
			rdata_d = snap_q[63:32];
		end else if (paddr == A_CLK_LO) begin
			rdata_d = snap_q[31:0];
		end else if (paddr == A_ADDEND) begin
			rdata_d = addend_q;
		end else if (paddr == A_CMD) begin
			rdata_d = '0;
		end else if (paddr == A_TGT_HI) begin
			rdata_d = target_q[63:32];
		end else if (paddr == A_TGT_LO) begin
			rdata_d = target_q[31:0];
		end else if (paddr == A_RLD_HI) begin
			rdata_d = rld_q[63:32];
		end else if (paddr == A_RLD_LO) begin
			rdata_d = rld_q[31:0];
		end else if (paddr == A_CFG) begin
			rdata_d = 32'(cfg_q);
		end else if (paddr == A_AEN) begin
			rdata_d = 32'(aen_q);
		end else if (paddr == A_USR_HI) begin
			rdata_d = 32'(usr_q[47:32]);
		end else if (paddr == A_USR_LO) begin
			rdata_d = usr_q[31:0];
		end else if (paddr == A_INT_STS) begin
			rdata_d = 32'(sts_q);
		end else if (paddr == A_INT_EN) begin
			rdata_d = 32'(inten_q);
		end else if (paddr >= A_GCAP && paddr < A_GCAP + 8'(8 * GPIO_N)
				&& paddr[1:0] == 2'h0) begin
			// GPIO n at A_GCAP + 8n: high word then low word
			rdata_d = goff[2] ? gcap_q[goff[3]][31:0]
				: gcap_q[goff[3]][63:32];
		end else if (paddr[7] && paddr[1:0] == 2'h0
				&& int'(sidx) < STR_N) begin
			case (paddr[3:2])
				2'h0: rdata_d = cap_clk[sidx][63:32];
				2'h1: rdata_d = cap_clk[sidx][31:0];
				2'h2: rdata_d = {cap_seq[sidx], cap_uid[sidx][47:32]};
				default: rdata_d = cap_uid[sidx][31:0];
			endcase
		end else begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			prdata  <= setup ? rdata_d : '0;
			pslverr <= setup & err_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			addend_q <= ADDEND_RST;
			cfg_q    <= '0;
			aen_q    <= '0;
			usr_q    <= '0;
			inten_q  <= '0;
		end else if (wr) begin
			if (paddr == A_ADDEND) addend_q <= pwdata;
			if (paddr == A_CFG) cfg_q <= pwdata[CFG_W-1:0];
			if (paddr == A_AEN) aen_q <= pwdata[AEN_W-1:0];
			if (paddr == A_USR_HI) usr_q[47:32] <= pwdata[15:0];
			if (paddr == A_USR_LO) usr_q[31:0] <= pwdata;
			if (paddr == A_INT_EN) inten_q <= pwdata[INT_W-1:0];
		end
	end

	// ==========================================================
	// Split 64-bit writes: clock, target, reload
	for (genvar i = 0; i < 3; i++) begin : g_pair
		logic [31:0] sh_q;
		logic        whi, wlo;
		assign whi = wr && paddr == PAIR_HI[i];
		assign wlo = wr && paddr == PAIR_LO[i];
		assign commit[i] = (whi & lf_q[i]) | (wlo & hf_q[i]);
		assign pv[i] = whi ? {pwdata, sh_q} : {sh_q, pwdata};
		always_ff @(posedge clk) begin
			if (!rstn) begin
				sh_q    <= '0;
				hf_q[i] <= 1'b0;
				lf_q[i] <= 1'b0;
			end else if (commit[i]) begin
				hf_q[i] <= 1'b0;
				lf_q[i] <= 1'b0;
			end else if (whi | wlo) begin
				sh_q    <= pwdata;
				hf_q[i] <= whi;
				lf_q[i] <= wlo;
			end
		end
	end

	// ==========================================================
	// Tunable clock and snapshot
	assign sum      = {1'b0, acc_q} + {1'b0, addend_q};
	assign carry    = sum[32];
	assign snap_cmd = wr && paddr == A_CMD && pwdata[CMD_SNAP];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			acc_q   <= '0;
			clock_q <= '0;
		end else begin
			acc_q <= sum[31:0];
			if (commit[0])
				clock_q <= pv[0];
			else if (carry)
				clock_q <= clock_q + 64'h1;
		end
	end

	// A clock write also refreshes the snapshot so reads see it
	always_ff @(posedge clk) begin
		if (!rstn)
			snap_q <= '0;
		else if (commit[0])
			snap_q <= pv[0];
		else if (snap_cmd)
			snap_q <= clock_q;
	end

	// ==========================================================
	// Target compare; edge of equality so one event per match
	assign eq  = clock_q == target_q;
	assign evt = eq & ~eq_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			eq_q     <= 1'b1; // Clock equals target in reset
			target_q <= '0;
			rld_q    <= '0;
		end else begin
			eq_q <= eq;
			if (commit[2]) rld_q <= pv[2];
			// A host write wins over an event in the same cycle
			if (commit[1])
				target_q <= pv[1];
			else if (evt && cfg_q[CFG_RELOAD])
				target_q <= rld_q;
			else if (evt)
				target_q <= target_q + {32'h0, rld_q[31:0]};
		end
	end

	// ==========================================================
	// GPIO capture inputs with minimum-width filter
	for (genvar g = 0; g < GPIO_N; g++) begin : g_gpio
		logic [1:0] cnt_q;
		assign gev[g] = gpio_in[g] && cnt_q == GPIO_HIT;
		always_ff @(posedge clk) begin
			if (!rstn)
				cnt_q <= '0;
			else if (!gpio_in[g])
				cnt_q <= '0;
			else if (cnt_q <= GPIO_HIT)
				cnt_q <= cnt_q + 2'h1;
		end
		always_ff @(posedge clk) begin
			if (!rstn)
				gcap_q[g] <= '0;
			else if (gev[g])
				gcap_q[g] <= clock_q;
		end
	end

	// ==========================================================
	// Frame detectors, stream s = port s/2, tx when s odd
	for (genvar s = 0; s < STR_N; s++) begin : g_str
		localparam int   P  = s / 2;
		localparam logic TX = 1'(s % 2);
		logic [63:0] ts_q;
		logic [7:0]  n_q, b, pay, want;
		logic [2:0]  k;
		logic [1:0]  ai;
		logic        fix_q, um_q, tag_q, typ_q, fb, ub;
		logic [15:0] seq_q;
		logic [47:0] uid_q;
		assign b    = fr_byte[8*s +: 8];
		assign pay  = tag_q ? PAY_TAG : PAY_UNTAG;
		assign k    = 3'h5 - n_q[2:0];
		assign ai   = 2'(b - MAC_FIRST);
		assign ub   = b == usr_q[{k, 3'h0} +: 8];
		assign want = (cfg_q[CFG_MS_LSB+P] ^ TX) ? MSG_DREQ : MSG_SYNC;
		always_comb begin
			if (n_q == DA_LEN - 8'h1)
				fb = b >= MAC_FIRST && b <= MAC_LAST
					&& aen_q[int'(ai)*PORT_N + P];
			else
				fb = b == MAC_PFX[{k - 3'h1, 3'h0} +: 8];
		end
		always_ff @(posedge clk) begin
			if (!rstn) begin
				ts_q  <= '0;
				n_q   <= '0;
				fix_q <= 1'b0;
				um_q  <= 1'b0;
				tag_q <= 1'b0;
				typ_q <= 1'b0;
				seq_q <= '0;
				uid_q <= '0;
			end else if (fr_sof[s]) begin
				ts_q  <= clock_q;
				n_q   <= '0;
				fix_q <= 1'b1;
				um_q  <= 1'b1;
				tag_q <= 1'b0;
				typ_q <= 1'b0;
			end else if (fr_vld[s]) begin
				if (n_q != CNT_MAX) n_q <= n_q + 8'h1;
				if (n_q < DA_LEN) begin
					fix_q <= fix_q & fb;
					um_q  <= um_q & ub;
				end
				if (n_q == VLAN_OFS) tag_q <= b == TPID_HI;
				if (n_q == VLAN_OFS + 8'h1 && b != TPID_LO)
					tag_q <= 1'b0;
				if (n_q >= pay + UUID_OFS
						&& n_q < pay + UUID_OFS + UUID_LEN)
					uid_q <= {uid_q[39:0], b};
				if (n_q >= pay + SEQ_OFS && n_q < pay + SEQ_OFS + SEQ_LEN)
					seq_q <= {seq_q[7:0], b};
				if (n_q == pay + MSG_OFS) typ_q <= b == want;
			end
		end
		assign tsev[s] = fr_eof[s] & fr_fcs_ok[s] & typ_q
			& (fix_q | (um_q & aen_q[AEN_USER*PORT_N + P]));
		always_ff @(posedge clk) begin
			if (!rstn) begin
				cap_clk[s] <= '0;
				cap_seq[s] <= '0;
				cap_uid[s] <= '0;
			end else if (tsev[s]) begin
				cap_clk[s] <= ts_q;
				cap_seq[s] <= seq_q;
				cap_uid[s] <= uid_q;
			end
		end
	end

	// ==========================================================
	// Status flags: set wins over any clear in the same cycle
	assign set = {evt, gev, tsev};
	assign clr = (wr && paddr == A_INT_STS ? pwdata[INT_W-1:0] : '0)
		| (INT_W'(|(gev & cfg_q[CFG_GCLR_LSB +: GPIO_N])) << INT_TMR);
	assign sts_d = (sts_q & ~clr) | set;
	assign gated = |(sts_q & inten_q);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sts_q <= '0;
			timestamp_unit_summary_event <= 1'b0;
		end else begin
			sts_q <= sts_d;
			timestamp_unit_summary_event <= gated;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	clk_tick_a: assert property (
		!commit[0] && carry |=> clock_q == $past(clock_q) + 64'h1)
		else $error("clock did not step on carry");
	clk_hold_a: assert property (
		!commit[0] && !carry |=> $stable(clock_q))
		else $error("clock moved without carry");
	clk_write_a: assert property (
		commit[0] |=> clock_q == $past(pv[0]) && snap_q == clock_q)
		else $error("clock write not applied");
	half_only_a: assert property (
		wr && paddr == A_TGT_LO && !hf_q[1] && !evt |=> $stable(target_q))
		else $error("target changed on one half");
	snap_hold_a: assert property (
		!snap_cmd && !commit[0] |=> $stable(snap_q))
		else $error("snapshot changed");
	tgt_reload_a: assert property (
		evt && !commit[1] && cfg_q[CFG_RELOAD] |=> target_q == $past(rld_q))
		else $error("reload target wrong");
	tgt_add_a: assert property (
		evt && !commit[1] && !cfg_q[CFG_RELOAD] && !commit[2]
		|=> target_q - $past(target_q) == {32'h0, rld_q[31:0]})
		else $error("add target wrong");
	tmr_flag_a: assert property (
		evt |=> sts_q[INT_TMR])
		else $error("timer flag not set");
	gpio_cap_a: assert property (
		gev[0] |=> gcap_q[0] == $past(clock_q))
		else $error("gpio capture wrong");
	gpio_width_a: assert property (
		gev[1] |-> $past(gpio_in[1]) && gpio_in[1])
		else $error("gpio pulse too short");
	ts_cap_a: assert property (
		tsev[2] |=> sts_q[INT_TS_LSB+2] && cap_clk[2] == $past(g_str[2].ts_q))
		else $error("stamp capture wrong");
	summary_a: assert property (
		gated |=> timestamp_unit_summary_event)
		else $error("summary missing");

	evt_c: cover property (evt ##[1:20] evt);
	ts_c: cover property (|tsev);
	gpio_c: cover property (gev[0] && cfg_q[CFG_GCLR_LSB]);
	split_c: cover property (commit[0]);

endmodule // ptp_clock_timestamp_events

// >>> design/ptp_tsu_pkg.sv
// Purpose: Constants for the PTP clock, time stamp and event block
// Assumes: APB word registers, 8-bit byte address
// Notes:   Each number of the block is named once here
package ptp_tsu_pkg;
	// ==========================================================
	// Sizes and timing
	localparam int PORT_N       = 3;
	localparam int STR_N        = 2 * PORT_N;
	localparam int GPIO_N       = 2;
	localparam int CLK_NS       = 40;
	localparam int GPIO_MIN_NS  = 40;
	localparam int GPIO_MIN_CYC = (GPIO_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] GPIO_HIT = 2'(GPIO_MIN_CYC);
	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] A_CLK_HI  = 8'h00;
	localparam logic [7:0] A_CLK_LO  = 8'h04;
	localparam logic [7:0] A_ADDEND  = 8'h08;
	localparam logic [7:0] A_CMD     = 8'h0C;
	localparam logic [7:0] A_TGT_HI  = 8'h10;
	localparam logic [7:0] A_TGT_LO  = 8'h14;
	localparam logic [7:0] A_RLD_HI  = 8'h18;
	localparam logic [7:0] A_RLD_LO  = 8'h1C;
	localparam logic [7:0] A_CFG     = 8'h20;
	localparam logic [7:0] A_AEN     = 8'h24;
	localparam logic [7:0] A_USR_HI  = 8'h28;
	localparam logic [7:0] A_USR_LO  = 8'h2C;
	localparam logic [7:0] A_INT_STS = 8'h30;
	localparam logic [7:0] A_INT_EN  = 8'h34;
	localparam logic [7:0] A_GCAP    = 8'h38;
	localparam logic [7:0] PAIR_HI [3] = '{A_CLK_HI, A_TGT_HI, A_RLD_HI};
	localparam logic [7:0] PAIR_LO [3] = '{A_CLK_LO, A_TGT_LO, A_RLD_LO};
	// ==========================================================
	// Fields and reset values
	localparam int CFG_W        = 6;
	localparam int CFG_MS_LSB   = 0;
	localparam int CFG_RELOAD   = 3;
	localparam int CFG_GCLR_LSB = 4;
	localparam int AEN_W        = 15;
	localparam int AEN_USER     = 4;
	localparam int INT_W        = 9;
	localparam int INT_TS_LSB   = 0;
	localparam int INT_GPIO_LSB = 6;
	localparam int INT_TMR      = 8;
	localparam int CMD_SNAP     = 0;
	localparam logic [31:0] ADDEND_RST = 32'h0000_0000;
	// ==========================================================
	// Frame layout
	localparam logic [39:0] MAC_PFX   = 40'h01_005E_0001;
	localparam logic [7:0]  MAC_FIRST = 8'h81;
	localparam logic [7:0]  MAC_LAST  = 8'h84;
	localparam logic [7:0]  DA_LEN    = 8'h06;
	localparam logic [7:0]  VLAN_OFS  = 8'h0C;
	localparam logic [7:0]  TPID_HI   = 8'h81;
	localparam logic [7:0]  TPID_LO   = 8'h00;
	localparam logic [7:0]  PAY_UNTAG = 8'h2A;
	localparam logic [7:0]  PAY_TAG   = 8'h2E;
	localparam logic [7:0]  UUID_OFS  = 8'h16;
	localparam logic [7:0]  UUID_LEN  = 8'h06;
	localparam logic [7:0]  SEQ_OFS   = 8'h1E;
	localparam logic [7:0]  SEQ_LEN   = 8'h02;
	localparam logic [7:0]  MSG_OFS   = 8'h20;
	localparam logic [7:0]  MSG_SYNC  = 8'h00;
	localparam logic [7:0]  MSG_DREQ  = 8'h01;
	localparam logic [7:0]  CNT_MAX   = 8'hFF;
endpackage

// >>> test/frame_source_model.sv
// Purpose: Frame streams from the PHYs and the switch fabric
// Assumes: One frame in flight at a time
// Notes:   Idle byte lanes show the inverse of the last byte
`timescale 1ns/10ps
module frame_source_model
	import ptp_tsu_pkg::*;
(
	input  wire logic               clk,
	output      logic [STR_N-1:0]   fr_sof,
	output      logic [STR_N-1:0]   fr_vld,
	output      logic [8*STR_N-1:0] fr_byte,
	output      logic [STR_N-1:0]   fr_eof,
	output      logic [STR_N-1:0]   fr_fcs_ok
);
	initial begin
		fr_sof    = '0;
		fr_vld    = '0;
		fr_byte   = '0;
		fr_eof    = '0;
		fr_fcs_ok = '0;
	end
	// ==========================================================
	// Start pulse, one byte a cycle, then end with the FCS verdict
	task automatic send(input int s, input logic [7:0] q[$],
		input logic ok);
		@(posedge clk);
		fr_sof[s] <= 1'b1;
		foreach (q[i]) begin
			@(posedge clk);
			fr_sof[s]        <= 1'b0;
			fr_vld[s]        <= 1'b1;
			fr_byte[8*s +: 8] <= q[i];
		end
		@(posedge clk);
		fr_vld[s]        <= 1'b0;
		fr_byte[8*s +: 8] <= ~q[q.size()-1];
		fr_eof[s]        <= 1'b1;
		fr_fcs_ok[s]     <= ok;
		@(posedge clk);
		fr_eof[s]    <= 1'b0;
		fr_fcs_ok[s] <= ~ok;
	endtask
endmodule // frame_source_model

// >>> test/ptp_clock_timestamp_events_tb_top.sv
// Purpose: Self-checking bench for the PTP clock and stamp block
// Assumes: Addend 0 keeps the clock still outside the rate test
// Notes:   Random values from a fixed seed
`timescale 1ns/10ps
module ptp_clock_timestamp_events_tb_top
	import ptp_tsu_pkg::*;
;
	logic               clk = 1'b0;
	logic               rstn = 1'b0;
	logic [7:0]         paddr = '0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [31:0]        pwdata = '0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic [STR_N-1:0]   fr_sof;
	logic [STR_N-1:0]   fr_vld;
	logic [8*STR_N-1:0] fr_byte;
	logic [STR_N-1:0]   fr_eof;
	logic [STR_N-1:0]   fr_fcs_ok;
	logic [GPIO_N-1:0]  gpio_in = '0;
	logic               summ;
	int                 bad_count = 0;
	int                 compares = 0;
	int                 cyc = 0;
	int                 sc;
	logic [31:0]        rd;
	logic               err;
	logic [63:0]        clk_v = '0;

	always #20 clk = ~clk;

	ptp_clock_timestamp_events ptp_clock_timestamp_events_inst (
		.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fr_sof(fr_sof), .fr_vld(fr_vld), .fr_byte(fr_byte),
		.fr_eof(fr_eof), .fr_fcs_ok(fr_fcs_ok), .gpio_in(gpio_in),
		.timestamp_unit_summary_event(summ));
	frame_source_model frame_source_model_inst (
		.clk(clk), .fr_sof(fr_sof), .fr_vld(fr_vld),
		.fr_byte(fr_byte), .fr_eof(fr_eof), .fr_fcs_ok(fr_fcs_ok));
	// ==========================================================
	// Checking and bus tasks
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard: whole run needs well under this many cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input string n, input logic [63:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask
	// Request held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(n, 64'(rd), 64'(e));
	endtask
	task automatic wr64(input int k, input logic [63:0] v);
		wr(PAIR_HI[k], v[63:32]);
		wr(PAIR_LO[k], v[31:0]);
	endtask
	task automatic snap(output logic [63:0] v);
		wr(A_CMD, 32'h1);
		sc = cyc;
		apb(1'b0, A_CLK_HI, '0);
		v[63:32] = rd;
		apb(1'b0, A_CLK_LO, '0);
		v[31:0] = rd;
	endtask
	task automatic fl(input int b, input logic e);
		apb(1'b0, A_INT_STS, '0);
		chk("flag", 64'(rd[b]), 64'(e));
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		logic [63:0] t0, t1, c, tg;
		logic [31:0] r, ad;
		logic [47:0] ua;
		logic [7:0]  q[$];
		logic [2:0]  port_master_select;
		logic [14:0] addr_enables;
		int          s, a, pay, c0, tp;
		logic        ok, miss, hit;
		void'($urandom(50));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, A_INT_STS, '0);
		chk("sts_rst", 64'(rd[INT_W-1:0]), 64'h0);
		rchk("addend_rst", A_ADDEND, 32'h0);
		chk("summ_rst", 64'(summ), 64'h0);
		apb(1'b0, 8'h60, '0);
		chk("slverr", 64'(err), 64'h1);
		snap(t0);
		chk("clk_rst", t0, 64'h0);
		// Split clock writes in both orders
		for (int k = 0; k < 2; k++) begin
			c = {$urandom, $urandom};
			wr(k ? A_CLK_LO : A_CLK_HI, k ? c[31:0] : c[63:32]);
			snap(t0);
			chk("clk_half", t0, clk_v);
			wr(k ? A_CLK_HI : A_CLK_LO, k ? c[63:32] : c[31:0]);
			snap(t0);
			chk("clk_whole", t0, c);
			clk_v = c;
		end
		// Rate: carries over n cycles are n*addend/2^32, within +-2
		ad = $urandom;
		wr(A_ADDEND, ad);
		snap(t0);
		c0 = sc;
		repeat (40) @(posedge clk);
		snap(t1);
		c = t1 - t0;
		chk("rate", 64'((c << 32) + 64'h2_0000_0000 - (sc - c0) * ad
			<= 64'h4_0000_0000), 64'h1);
		repeat (5) @(posedge clk);
		rchk("hold_hi", A_CLK_HI, t1[63:32]);
		rchk("hold_lo", A_CLK_LO, t1[31:0]);
		wr(A_ADDEND, 32'h0);
		snap(clk_v);
		// Target compare, add mode, wrap, reload mode
		wr(A_CFG, 32'h0);
		wr(A_INT_EN, 32'h100);
		wr(A_INT_STS, 32'h1FF);
		r = $urandom | 32'h2;
		c = clk_v;
		wr(A_RLD_HI, $urandom);
		wr(A_RLD_LO, r);
		wr(A_TGT_LO, c[31:0]);
		fl(INT_TMR, 1'b0);
		wr(A_TGT_HI, c[63:32]);
		fl(INT_TMR, 1'b1);
		chk("summ_on", 64'(summ), 64'h1);
		wr(A_INT_EN, 32'h0);
		repeat (2) @(posedge clk);
		chk("summ_off", 64'(summ), 64'h0);
		wr(A_INT_STS, 32'h100);
		fl(INT_TMR, 1'b0);
		wr64(0, c);
		fl(INT_TMR, 1'b0);
		wr64(0, c + r);
		fl(INT_TMR, 1'b1);
		wr(A_INT_STS, 32'h100);
		wr64(1, '1);
		wr64(0, '1);
		wr(A_INT_STS, 32'h100);
		wr64(0, 64'(r) - 1);
		fl(INT_TMR, 1'b1);
		wr(A_CFG, 32'h8);
		t1 = {$urandom, $urandom};
		wr64(2, t1);
		wr64(1, 64'(r) - 1);
		wr(A_INT_STS, 32'h100);
		wr64(0, t1);
		fl(INT_TMR, 1'b1);
		clk_v = t1;
		// GPIO: only input 1 may clear the timer flag
		wr(A_CFG, 32'h20);
		for (int g = 0; g < GPIO_N; g++) begin
			gpio_in[g] <= 1'b1;
			@(posedge clk);
			gpio_in[g] <= 1'b0;
			repeat (3) @(posedge clk);
			fl(INT_GPIO_LSB + g, 1'b0);
			gpio_in[g] <= 1'b1;
			repeat (3) @(posedge clk);
			gpio_in[g] <= 1'b0;
			repeat (3) @(posedge clk);
			fl(INT_GPIO_LSB + g, 1'b1);
			fl(INT_TMR, g == 0);
			rchk("gcap_hi", 8'(A_GCAP + 8*g), clk_v[63:32]);
			rchk("gcap_lo", 8'(A_GCAP + 8*g + 4), clk_v[31:0]);
		end
		// Frames over every stream and address, random the rest
		ua = 48'({$urandom, $urandom});
		wr(A_USR_HI, 32'(ua[47:32]));
		wr(A_USR_LO, ua[31:0]);
		for (int i = 0; i < 40; i++) begin
			s = i % STR_N;
			a = i % 5;
			port_master_select = 3'($urandom);
			addr_enables = 15'($urandom);
			tg = {$urandom, $urandom};
			ok = ($urandom % 4) != 0;
			miss = ($urandom % 6) == 0;
			tp = $urandom % 3;
			pay = ($urandom % 2) ? PAY_TAG : PAY_UNTAG;
			wr(A_CFG, 32'(port_master_select));
			wr(A_AEN, 32'(addr_enables));
			wr(A_INT_STS, 32'h1FF);
			q = {};
			repeat (pay + 48) q.push_back(8'($urandom));
			c = (a < 4) ? {16'h0, MAC_PFX, 8'(MAC_FIRST + a)}
				: {16'h0, ua};
			if (miss)
				c[41] = ~c[41];
			for (int j = 0; j < 6; j++) begin
				q[j] = c[47-8*j -: 8];
				q[pay+22+j] = tg[47-8*j -: 8];
			end
			if (pay == PAY_TAG) begin
				q[12] = TPID_HI;
				q[13] = TPID_LO;
			end
			q[pay-30] = 8'h08;
			q[pay-29] = 8'h00;
			q[pay-28] = 8'h45;
			q[pay-19] = 8'h11;
			q[pay+30] = tg[63:56];
			q[pay+31] = tg[55:48];
			q[pay+32] = 8'(tp);
			hit = ok && !miss && addr_enables[a*3 + s/2]
				&& (tp == ((s % 2) ^ port_master_select[s/2]));
			frame_source_model_inst.send(s, q, ok);
			repeat (2) @(posedge clk);
			apb(1'b0, A_INT_STS, '0);
			chk("ts_flag", 64'(rd[STR_N-1:0]), 64'(hit) << s);
			if (hit) begin
				rchk("ts_hi", 8'(8'h80 + 16*s), clk_v[63:32]);
				rchk("ts_lo", 8'(8'h84 + 16*s), clk_v[31:0]);
				rchk("ts_seq", 8'(8'h88 + 16*s), tg[63:32]);
				rchk("ts_uuid", 8'(8'h8C + 16*s), tg[31:0]);
			end
		end
		tally_and_finish();
	end
endmodule // ptp_clock_timestamp_events_tb_top
